/* fmb_bus_ctrl.sv */
`timescale 1ns/1ps
`include "fmb_regs.svh"

// Overview of operation
// - async mode latches address from bus and upper inputs on latch rise
// - burst mode latches address on latch rise or selected clock edge
// - page mode loads four-word buffer, word picked by two low bits
// - id reads are single accesses, never multi-word bursts; status reads still burst
// - read data driven only while chip select and output gate low
// - write needs select and write low, gate high, reset and protect high
// - write data captured when write strobe or chip select rises first
// - glitches under about 10ns on select, write, gate are ignored
// - writes are asynchronous; burst clock ignored during write
// - burst waits two to six clocks then one word per clock
// - burst order linear or interleaved, length four, eight or endless
// - wait marks extra delay when crossing a 32-word boundary
// - array reads in one bank run while other bank programs
// - outputs float while output gate and write strobe both high
// - chip select high and controller idle gives standby, outputs float
// - page mode enters pseudo-standby after 150ns idle, outputs kept
// - power-down enabled and reset low floats outputs regardless
// - locked block is write protected while protect input is low
// - id mode offset 00h gives maker code, 01h device code
// - id mode offset 02h gives lock and protect status of block
// - unprotecting a locked block is refused unless protect input high
// - bus floats while deselected, gate high, or reset low
// - burst clock ignored in page reads and in writes
// - wait asserts in the wait cycle or one clock earlier
// - read mode bit 0 selects burst, 1 page, page after reset
module fmb_bus_ctrl import fmb_pkg::*; #(
  parameter logic [7:0] MAKER_CODE = 8'h5a,  // arbitrary value
  parameter logic [7:0] DEVICE_CODE = 8'hc3  // arbitrary value
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire fmb_pins_t pins_in,
  output logic [15:0] bus_out,
  output logic bus_oe,
  output logic wait_out,
  output logic wait_oe,
  input wire fmb_cfg_t cfg_in,
  input wire logic cfg_wr,
  input wire logic auto_select_instruction,
  output logic [20:0] array_addr,
  input wire logic [15:0] array_rd_data,
  input wire logic pe_busy,
  input wire logic pe_bank,
  input wire logic [15:0] pe_status,
  output logic wr_strobe,
  output logic [20:0] wr_addr,
  output logic [15:0] wr_data,
  output logic [8:0] blk_addr,
  input wire logic blk_protected,
  input wire logic blk_locked,
  output logic prog_inhibit,
  input wire logic unprotect_req,
  output logic unprotect_ok,
  output logic unprotect_refused,
  output logic standby,
  output logic auto_standby,
  output logic powerdown
);

  // ----------------------------------------------------------------
  // pin sampling
  // ----------------------------------------------------------------
  fmb_pins_t pf;
  fmb_pins_t pp_reg;

  fmb_sync_filt #(
    .W($bits(fmb_pins_t)),
    .RST_VAL(`FMB_PIN_RESET)
  ) u_sync (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .async_in(pins_in),
    .filt_out(pf)
  );

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  fmb_cfg_t cfg_reg, cfg_next;
  logic [20:0] addr_reg, addr_next;
  logic wr_act_reg, wr_act_next;
  logic wr_strobe_reg, wr_strobe_next;
  logic [20:0] wr_addr_reg, wr_addr_next;
  logic [15:0] wr_data_reg, wr_data_next;
  fmb_bst_t bst_reg, bst_next;
  logic [2:0] lat_reg, lat_next;
  logic [20:0] baddr_reg, baddr_next;
  logic [2:0] bstart_reg, bstart_next;
  logic [2:0] bcnt_reg, bcnt_next;
  logic xing_reg, xing_next;
  logic [15:0] out_reg, out_next;
  logic [18:0] ptag_reg, ptag_next;
  logic pvalid_reg, pvalid_next;
  logic ld_busy_reg, ld_busy_next;
  logic [1:0] ld_idx_reg, ld_idx_next;
  logic [15:0] page_reg [4];
  logic [15:0] page_next [4];
  logic [`FMB_AUTO_SB_W-1:0] as_cnt_reg, as_cnt_next;
  logic inhibit_reg, ok_reg, refused_reg, standby_reg;

  // ----------------------------------------------------------------
  // decoded pin events
  // ----------------------------------------------------------------
  logic burst_mode, k_edge, l_rise, wr_cond, start, advance;
  logic [20:0] addr_live, addr_cur, rd_addr, step_addr;
  logic [15:0] rd_word, arr_word;
  logic [2:0] lat_eff, grp_mask, cnt_inc, low_bits;
  logic pwrdn, locked_wp;

  assign burst_mode = !cfg_reg.read_mode_select_bit;
  assign k_edge = cfg_reg.k_falling ? (pp_reg.clk_k & !pf.clk_k) :
                  (!pp_reg.clk_k & pf.clk_k);
  assign l_rise = !pp_reg.latch_n & pf.latch_n;
  assign addr_live = {pf.upper_address_inputs, pf.muxed_addr_data_bus};
  assign addr_cur = pf.latch_n ? addr_reg : addr_live;
  assign wr_cond = !pf.ce_n & !pf.we_n & pf.oe_n & pf.reset_powerdown_n &
                   pf.wp_n;
  // burst starts on latch rise or on a clock edge with latch open
  assign start = burst_mode & !wr_act_reg & !pf.ce_n & pf.reset_powerdown_n &
                 (l_rise | (k_edge & !pf.latch_n));
  assign lat_eff = (cfg_reg.latency < `FMB_LAT_MIN) ? `FMB_LAT_MIN :
                   (cfg_reg.latency > `FMB_LAT_MAX) ? `FMB_LAT_MAX :
                   cfg_reg.latency;
  assign pwrdn = cfg_reg.pd_en & !pf.reset_powerdown_n;
  assign locked_wp = blk_locked & !pf.wp_n;

  // ----------------------------------------------------------------
  // address latch and configuration
  // ----------------------------------------------------------------
  always_comb begin
    addr_next = pf.latch_n ? addr_reg : addr_live;
    cfg_next = cfg_reg;
    if (cfg_wr) begin
      cfg_next = cfg_in;
    end
    if (!pf.reset_powerdown_n) begin
      cfg_next.read_mode_select_bit = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // write cycle capture
  // ----------------------------------------------------------------
  always_comb begin
    wr_act_next = wr_act_reg;
    wr_strobe_next = 1'b0;
    wr_addr_next = wr_addr_reg;
    wr_data_next = wr_data_reg;
    if (wr_act_reg) begin
      if (pf.ce_n | pf.we_n) begin
        wr_act_next = 1'b0;
        wr_strobe_next = 1'b1;
        wr_addr_next = addr_reg;
      end else begin
        wr_data_next = pf.muxed_addr_data_bus;
      end
    end else if (wr_cond) begin
      wr_act_next = 1'b1;
      wr_data_next = pf.muxed_addr_data_bus;
    end
  end

  // ----------------------------------------------------------------
  // read word selection
  // ----------------------------------------------------------------
  always_comb begin
    rd_addr = burst_mode ? baddr_reg : addr_cur;
    arr_word = burst_mode ? array_rd_data : page_reg[addr_cur[1:0]];
    rd_word = arr_word;
    if (auto_select_instruction) begin
      unique case (rd_addr[7:0])
        `FMB_ID_MAKER: rd_word = {8'h00, MAKER_CODE};
        `FMB_ID_DEVICE: rd_word = {8'h00, DEVICE_CODE};
        `FMB_ID_PROT: rd_word = {14'h0000, blk_locked, blk_protected};
        default: rd_word = 16'h0000;
      endcase
    end else if (pe_busy & ((rd_addr >= `FMB_BANK_SPLIT) == pe_bank)) begin
      rd_word = pe_status;
    end
    // other bank keeps plain array data with no stall
  end

  // ----------------------------------------------------------------
  // burst word stepping
  // ----------------------------------------------------------------
  always_comb begin
    grp_mask = (cfg_reg.burst_len == FMB_LEN_4) ? `FMB_GRP4_MASK :
               `FMB_GRP8_MASK;
    cnt_inc = bcnt_reg + 3'h1;
    low_bits = cfg_reg.interleave ? (bstart_reg ^ cnt_inc) :
               (bstart_reg + cnt_inc);
    if (cfg_reg.burst_len == FMB_LEN_CONT) begin
      step_addr = baddr_reg + 21'h000001;
    end else begin
      step_addr = {baddr_reg[20:3],
                   (baddr_reg[2:0] & ~grp_mask) | (low_bits & grp_mask)};
    end
  end

  // ----------------------------------------------------------------
  // burst sequencer
  // ----------------------------------------------------------------
  always_comb begin
    bst_next = bst_reg;
    lat_next = lat_reg;
    baddr_next = baddr_reg;
    bstart_next = bstart_reg;
    bcnt_next = bcnt_reg;
    xing_next = xing_reg;
    out_next = burst_mode ? out_reg : rd_word;
    advance = 1'b0;
    if (start) begin
      bst_next = FMB_B_LAT;
      lat_next = lat_eff;
      baddr_next = pf.latch_n ? addr_reg : addr_live;
      bstart_next = pf.latch_n ? addr_reg[2:0] : addr_live[2:0];
      bcnt_next = 3'h0;
      xing_next = 1'b0;
    end else if (pf.ce_n | !pf.reset_powerdown_n | !burst_mode) begin
      bst_next = FMB_B_IDLE;
    end else if (k_edge & !wr_act_reg) begin
      unique case (bst_reg)
        FMB_B_IDLE: bst_next = FMB_B_IDLE;
        FMB_B_LAT: begin
          lat_next = lat_reg - 3'h1;
          if (lat_reg <= 3'h1) begin
            advance = 1'b1;
          end
        end
        FMB_B_DATA: begin
          if (xing_reg) begin
            bst_next = FMB_B_WAIT;
            xing_next = 1'b0;
          end else begin
            advance = 1'b1;
          end
        end
        FMB_B_WAIT: advance = 1'b1;
      endcase
      if (advance) begin
        out_next = rd_word;
        baddr_next = step_addr;
        bcnt_next = cnt_inc;
        xing_next = (cfg_reg.burst_len == FMB_LEN_CONT) &
                    (baddr_reg[4:0] == `FMB_XING_LAST);
        bst_next = auto_select_instruction ? FMB_B_IDLE : FMB_B_DATA;
      end
    end
  end

  // ----------------------------------------------------------------
  // page buffer loader
  // ----------------------------------------------------------------
  always_comb begin
    ptag_next = ptag_reg;
    pvalid_next = pvalid_reg;
    ld_busy_next = ld_busy_reg;
    ld_idx_next = ld_idx_reg;
    page_next = page_reg;
    if (!pf.reset_powerdown_n | burst_mode) begin
      pvalid_next = 1'b0;
      ld_busy_next = 1'b0;
    end else if (ld_busy_reg) begin
      page_next[ld_idx_reg] = array_rd_data;
      ld_idx_next = ld_idx_reg + 2'h1;
      if (ld_idx_reg == `FMB_PAGE_LAST) begin
        ld_busy_next = 1'b0;
        pvalid_next = 1'b1;
      end
    end else if (!wr_act_reg & (!pvalid_reg | (addr_cur[20:2] != ptag_reg))) begin
      ptag_next = addr_cur[20:2];
      pvalid_next = 1'b0;
      ld_busy_next = 1'b1;
      ld_idx_next = 2'h0;
    end
  end

  // ----------------------------------------------------------------
  // automatic standby idle counter
  // ----------------------------------------------------------------
  always_comb begin
    as_cnt_next = as_cnt_reg;
    if (burst_mode | pf.ce_n | (pf != pp_reg)) begin
      as_cnt_next = '0;
    end else if (as_cnt_reg != `FMB_AUTO_SB_W'(`FMB_AUTO_SB_CYC)) begin
      as_cnt_next = as_cnt_reg + `FMB_AUTO_SB_W'(1);
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      pp_reg <= `FMB_PIN_RESET;
      cfg_reg <= `FMB_CFG_RESET;
      addr_reg <= '0;
      wr_act_reg <= 1'b0;
      wr_strobe_reg <= 1'b0;
      wr_addr_reg <= '0;
      wr_data_reg <= '0;
      bst_reg <= FMB_B_IDLE;
      lat_reg <= 3'h0;
      baddr_reg <= '0;
      bstart_reg <= 3'h0;
      bcnt_reg <= 3'h0;
      xing_reg <= 1'b0;
      out_reg <= '0;
      ptag_reg <= '0;
      pvalid_reg <= 1'b0;
      ld_busy_reg <= 1'b0;
      ld_idx_reg <= 2'h0;
      page_reg <= '{default: 16'h0000};
      as_cnt_reg <= '0;
      inhibit_reg <= 1'b0;
      ok_reg <= 1'b0;
      refused_reg <= 1'b0;
      standby_reg <= 1'b0;
    end else begin
      pp_reg <= pf;
      cfg_reg <= cfg_next;
      addr_reg <= addr_next;
      wr_act_reg <= wr_act_next;
      wr_strobe_reg <= wr_strobe_next;
      wr_addr_reg <= wr_addr_next;
      wr_data_reg <= wr_data_next;
      bst_reg <= bst_next;
      lat_reg <= lat_next;
      baddr_reg <= baddr_next;
      bstart_reg <= bstart_next;
      bcnt_reg <= bcnt_next;
      xing_reg <= xing_next;
      out_reg <= out_next;
      ptag_reg <= ptag_next;
      pvalid_reg <= pvalid_next;
      ld_busy_reg <= ld_busy_next;
      ld_idx_reg <= ld_idx_next;
      page_reg <= page_next;
      as_cnt_reg <= as_cnt_next;
      inhibit_reg <= locked_wp;
      ok_reg <= unprotect_req & !locked_wp;
      refused_reg <= unprotect_req & locked_wp;
      standby_reg <= pf.ce_n & !pe_busy;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // drive only on a read cycle; float otherwise
  assign bus_oe = !pf.ce_n & !pf.oe_n & pf.reset_powerdown_n & !pwrdn;
  assign wait_oe = bus_oe;
  assign bus_out = out_reg;
  assign wait_out = (bst_reg == FMB_B_WAIT) |
                    (cfg_reg.wait_early & (bst_reg == FMB_B_DATA) &
                     xing_reg);
  assign array_addr = ld_busy_reg ? {ptag_reg, ld_idx_reg} : rd_addr;
  assign wr_strobe = wr_strobe_reg;
  assign wr_addr = wr_addr_reg;
  assign wr_data = wr_data_reg;
  assign blk_addr = addr_cur[20:12];
  assign prog_inhibit = inhibit_reg;
  assign unprotect_ok = ok_reg;
  assign unprotect_refused = refused_reg;
  assign standby = standby_reg;
  assign auto_standby = (as_cnt_reg == `FMB_AUTO_SB_W'(`FMB_AUTO_SB_CYC));
  assign powerdown = pwrdn;

endmodule : fmb_bus_ctrl

/* fmb_regs.svh */
`ifndef FMB_REGS_SVH
`define FMB_REGS_SVH

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define FMB_CLK_PERIOD_NS 10
`define FMB_AUTO_SB_NS 150
`define FMB_AUTO_SB_CYC \
  ((`FMB_AUTO_SB_NS + `FMB_CLK_PERIOD_NS - 1) / `FMB_CLK_PERIOD_NS)
`define FMB_AUTO_SB_W 5

// ----------------------------------------------------------------
// burst and page geometry
// ----------------------------------------------------------------
`define FMB_LAT_MIN 3'h2
`define FMB_LAT_MAX 3'h6
`define FMB_PAGE_LAST 2'h3
`define FMB_XING_LAST 5'h1f
`define FMB_GRP4_MASK 3'h3
`define FMB_GRP8_MASK 3'h7

// ----------------------------------------------------------------
// identification read offsets (low address byte)
// ----------------------------------------------------------------
`define FMB_ID_MAKER 8'h00
`define FMB_ID_DEVICE 8'h01
`define FMB_ID_PROT 8'h02

// ----------------------------------------------------------------
// bank split and reset values
// ----------------------------------------------------------------
`define FMB_BANK_SPLIT 21'h180000
`define FMB_CFG_RESET 10'h280
`define FMB_PIN_RESET 28'hfc00000

`endif

/* fmb_pkg.sv */
package fmb_pkg;

  // ----------------------------------------------------------------
  // burst length selection
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    FMB_LEN_4 = 2'h0,
    FMB_LEN_8 = 2'h1,
    FMB_LEN_CONT = 2'h2
  } fmb_len_t;

  // configuration bits steering the bus logic
  typedef struct packed {
    logic read_mode_select_bit;
    logic [2:0] latency;
    logic interleave;
    fmb_len_t burst_len;
    logic k_falling;
    logic wait_early;
    logic pd_en;
  } fmb_cfg_t;

  // external pins, all asynchronous to clk_sys
  typedef struct packed {
    logic ce_n;
    logic oe_n;
    logic we_n;
    logic latch_n;
    logic reset_powerdown_n;
    logic wp_n;
    logic clk_k;
    logic [4:0] upper_address_inputs;
    logic [15:0] muxed_addr_data_bus;
  } fmb_pins_t;

  // burst sequencer states, gray along idle-lat-data-wait
  typedef enum logic [1:0] {
    FMB_B_IDLE = 2'b00,
    FMB_B_LAT = 2'b01,
    FMB_B_DATA = 2'b11,
    FMB_B_WAIT = 2'b10
  } fmb_bst_t;

endpackage : fmb_pkg

/* fmb_sync_filt.sv */
`timescale 1ns/1ps

// ----------------------------------------------------------------
// two-flop synchroniser plus two-sample agreement filter
// ----------------------------------------------------------------
module fmb_sync_filt #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] filt_out
);

  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;
  logic [W-1:0] out_reg;
  logic [W-1:0] out_next;

  // a bit changes only once two samples agree; single-sample pulses die
  always_comb begin
    out_next = (s2_reg & s3_reg) | (out_reg & (s2_reg | s3_reg));
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      s1_reg <= RST_VAL;
      s2_reg <= RST_VAL;
      s3_reg <= RST_VAL;
      out_reg <= RST_VAL;
    end else begin
      s1_reg <= async_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      out_reg <= out_next;
    end
  end

  assign filt_out = out_reg;

endmodule : fmb_sync_filt

/* fmb_array_model.sv */
`timescale 1ns/1ps

// ----------------------------------------------------------------
// array and lock-bit model behind the bus controller
// ----------------------------------------------------------------
module fmb_array_model (
  input wire logic [20:0] array_addr,
  output logic [15:0] array_rd_data,
  input wire logic [8:0] blk_addr,
  output logic blk_protected,
  output logic blk_locked
);
  // array words follow the address with no delay
  assign array_rd_data = array_addr[15:0] ^ 16'h3c3c;
  // per-block lock and protect bits from the block number
  assign blk_locked = blk_addr[0];
  assign blk_protected = blk_addr[1];
endmodule : fmb_array_model

/* fmb_bus_ctrl_props.sv */
`timescale 1ns/1ps

// ----------------------------------------------------------------
// pin-level checks of the bus controller
// ----------------------------------------------------------------
module fmb_bus_ctrl_props import fmb_pkg::*; (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire fmb_pins_t pins_in,
  input wire logic bus_oe,
  input wire logic wr_strobe,
  input wire logic pe_busy,
  input wire logic blk_locked,
  input wire logic prog_inhibit,
  input wire logic unprotect_req,
  input wire logic unprotect_ok,
  input wire logic unprotect_refused,
  input wire logic standby
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  // pins held long enough to pass the input filter
  sequence gate_high_held;
    pins_in.oe_n [*8];
  endsequence
  sequence wp_low_held;
    !pins_in.wp_n [*8];
  endsequence

  AST_OE_GATE: assert property (gate_high_held |-> !bus_oe)
    else $error("bus driven with output gate high");
  AST_OE_SELECT: assert property (pins_in.ce_n [*8] |-> !bus_oe)
    else $error("bus driven while deselected");
  AST_OE_RESET: assert property
    (!pins_in.reset_powerdown_n [*8] |-> !bus_oe)
    else $error("bus driven during reset pin low");
  AST_STANDBY: assert property
    ((pins_in.ce_n && !pe_busy) [*8] |-> standby && !bus_oe)
    else $error("standby missing while deselected and idle");
  AST_WR_PROT: assert property (wp_low_held |-> !wr_strobe)
    else $error("write taken with protect low");
  AST_WR_EDGE: assert property
    (wr_strobe |-> $past(pins_in.we_n, 3) || $past(pins_in.ce_n, 3))
    else $error("write taken before strobe rise");
  AST_LOCK: assert property (prog_inhibit |-> $past(blk_locked))
    else $error("inhibit on unlocked block");
  AST_UNPROT: assert property
    (wp_low_held ##0 (unprotect_req && blk_locked)
     |=> unprotect_refused && !unprotect_ok)
    else $error("locked block unprotected with protect low");
  AST_UNPROT_ONE: assert property
    (unprotect_req |=> unprotect_ok != unprotect_refused)
    else $error("unprotect answer missing or doubled");
endmodule : fmb_bus_ctrl_props

bind fmb_bus_ctrl fmb_bus_ctrl_props u_props (
  .clk_sys(clk_sys),
  .rst_b(rst_b),
  .pins_in(pins_in),
  .bus_oe(bus_oe),
  .wr_strobe(wr_strobe),
  .pe_busy(pe_busy),
  .blk_locked(blk_locked),
  .prog_inhibit(prog_inhibit),
  .unprotect_req(unprotect_req),
  .unprotect_ok(unprotect_ok),
  .unprotect_refused(unprotect_refused),
  .standby(standby)
);

/* fmb_bus_ctrl_bench.sv */
`timescale 1ns/1ps
`include "fmb_regs.svh"

module fmb_bus_ctrl_bench import fmb_pkg::*; ();
  localparam logic [7:0] MK = 8'h3e; // arbitrary value
  localparam logic [7:0] DV = 8'h71; // arbitrary value
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  fmb_pins_t p = `FMB_PIN_RESET;
  fmb_cfg_t cfg = `FMB_CFG_RESET;
  logic cfg_wr = 1'b0, asel = 1'b0, pe_busy = 1'b0, pe_bank = 1'b0;
  logic unprotect_req = 1'b0;
  logic [15:0] pe_status = 16'hbe0f;
  logic [15:0] bus_out, wr_data, rdd;
  logic [20:0] aa, wr_addr;
  logic [8:0] blk;
  logic bus_oe, wait_out, wait_oe, wr_strobe, prot, lock, prog_inhibit;
  logic unprotect_ok, unprotect_refused, standby, auto_standby, powerdown;
  int miscompares = 0;
  int samples_checked = 0;

  always #5 clk_sys = ~clk_sys;

  fmb_bus_ctrl #(.MAKER_CODE(MK), .DEVICE_CODE(DV)) uut (
    .clk_sys(clk_sys), .rst_b(rst_b), .pins_in(p), .bus_out(bus_out),
    .bus_oe(bus_oe), .wait_out(wait_out), .wait_oe(wait_oe),
    .cfg_in(cfg), .cfg_wr(cfg_wr), .auto_select_instruction(asel),
    .array_addr(aa), .array_rd_data(rdd), .pe_busy(pe_busy),
    .pe_bank(pe_bank), .pe_status(pe_status), .wr_strobe(wr_strobe),
    .wr_addr(wr_addr), .wr_data(wr_data), .blk_addr(blk),
    .blk_protected(prot), .blk_locked(lock), .prog_inhibit(prog_inhibit),
    .unprotect_req(unprotect_req), .unprotect_ok(unprotect_ok),
    .unprotect_refused(unprotect_refused), .standby(standby),
    .auto_standby(auto_standby), .powerdown(powerdown));

  fmb_array_model u_mem (.array_addr(aa), .array_rd_data(rdd),
    .blk_addr(blk), .blk_protected(prot), .blk_locked(lock));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [15:0] fdat(logic [20:0] a);
    return a[15:0] ^ 16'h3c3c;
  endfunction : fdat

  task automatic tick(int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : tick

  task automatic chk(logic [20:0] got, logic [20:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected %0t got %h want %h", $time, got, exp);
    end
  endtask : chk

  task automatic setcfg(fmb_cfg_t c);
    cfg = c;
    cfg_wr = 1'b1;
    tick(1);
    cfg_wr = 1'b0;
    tick(1);
  endtask : setcfg

  // address phase: latch transparent while low, held at rise
  task automatic latch(logic [20:0] a);
    p.ce_n = 1'b0;
    {p.upper_address_inputs, p.muxed_addr_data_bus} = a;
    p.latch_n = 1'b0;
    tick(6);
    p.latch_n = 1'b1;
    tick(2);
    p.muxed_addr_data_bus = ~a[15:0];
  endtask : latch

  task automatic rd(logic [20:0] a, logic [15:0] e);
    latch(a);
    tick(4);
    chk(bus_oe, 1'b0);
    chk(wait_oe, 1'b0);
    p.oe_n = 1'b0;
    tick(24);
    chk(bus_oe, 1'b1);
    chk(bus_out, e);
    chk(auto_standby, 1'b1);
    p.oe_n = 1'b1;
    p.ce_n = 1'b1;
    tick(8);
  endtask : rd

  task automatic wr(logic [20:0] a, logic [15:0] d, int w, logic e);
    int n;
    latch(a);
    tick(1);
    p.muxed_addr_data_bus = d;
    // a short pulse is centred on a clock edge so one sample sees it
    if (w < 10) #7;
    p.we_n = 1'b0;
    #w;
    p.we_n = 1'b1;
    n = 0;
    while (wr_strobe !== 1'b1 && n < 15) begin
      tick(1);
      n++;
    end
    chk(wr_strobe, e);
    if (e) begin
      chk(wr_addr, a);
      chk(wr_data, d);
    end
    p.ce_n = 1'b1;
    p.muxed_addr_data_bus = ~d;
    tick(8);
  endtask : wr

  task automatic unprot(logic ok);
    unprotect_req = 1'b1;
    tick(1);
    unprotect_req = 1'b0;
    chk(unprotect_ok, ok);
    chk(unprotect_refused, !ok);
  endtask : unprot

  // burst: start at latch rise, then one burst clock period per step
  task automatic burst(logic [2:0] lat, logic il, fmb_len_t ln,
                       logic [20:0] a, logic kf, logic we);
    logic [20:0] m, i, e;
    logic wc, x;
    int n;
    m = (ln == FMB_LEN_CONT) ? 21'h1fffff :
        (ln == FMB_LEN_8) ? 21'h7 : 21'h3;
    n = (ln == FMB_LEN_8) ? 8 : 4;
    i = '0;
    wc = 1'b0;
    x = 1'b0;
    setcfg('{1'b0, lat, il, ln, kf, we, 1'b0});
    latch(a);
    p.oe_n = 1'b0;
    for (int k = 1; k < lat + n; k++) begin
      p.clk_k = 1'b1;
      #62.5;
      p.clk_k = 1'b0;
      #62.5;
      // one wait cycle follows the word at the end of a 32-word row
      if (k > lat) begin
        wc = !wc && x;
        if (!wc) i = i + 21'h1;
      end
      e = (a & ~m) | ((il ? (a ^ i) : (a + i)) & m);
      x = (ln == FMB_LEN_CONT) && (e[4:0] == 5'h1f);
      if (k >= lat) begin
        chk(bus_out, fdat(e));
        chk(wait_out, wc | (we & x));
      end
    end
    tick(1);
    chk(wait_oe, 1'b1);
    chk(auto_standby, 1'b0);
    p.ce_n = 1'b1;
    p.oe_n = 1'b1;
    tick(4);
    setcfg(`FMB_CFG_RESET);
  endtask : burst

  task test_done;
    $display("checked %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : test_done

  // ----------------------------------------------------------------
  // watchdog
  // ----------------------------------------------------------------
  initial begin
    #400000;
    miscompares++;
    $display("unexpected %0t watchdog expired", $time);
    test_done;
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (4) @(posedge clk_sys);
    #1;
    rst_b = 1'b1;
    tick(6);
    chk(bus_oe, 1'b0);
    chk(standby, 1'b1);
    for (int i = 0; i < 4; i++) rd(21'h012340 | i, fdat(21'h012340 | i));
    pe_busy = 1'b1;
    pe_bank = 1'b1;
    rd(21'h1a0005, pe_status);
    rd(21'h000005, fdat(21'h000005));
    pe_busy = 1'b0;
    asel = 1'b1;
    rd(21'h1f0000, {8'h00, MK});
    rd(21'h1f0001, {8'h00, DV});
    for (int b = 0; b < 4; b++) rd({9'(b), 12'h002}, {14'h0, b[0], b[1]});
    asel = 1'b0;
    wr(21'h004321, 16'ha55a, 60, 1'b1);
    wr(21'h004322, 16'h1234, 5, 1'b0);
    p.wp_n = 1'b0;
    wr(21'h004323, 16'h0f0f, 60, 1'b0);
    rd(21'h001000, fdat(21'h001000));
    tick(8);
    chk(prog_inhibit, 1'b1);
    unprot(1'b0);
    p.wp_n = 1'b1;
    tick(8);
    chk(prog_inhibit, 1'b0);
    unprot(1'b1);
    setcfg('{1'b1, 3'h2, 1'b0, FMB_LEN_4, 1'b0, 1'b0, 1'b1});
    p.ce_n = 1'b0;
    p.oe_n = 1'b0;
    p.reset_powerdown_n = 1'b0;
    tick(8);
    chk(powerdown, 1'b1);
    chk(bus_oe, 1'b0);
    p.reset_powerdown_n = 1'b1;
    p.ce_n = 1'b1;
    p.oe_n = 1'b1;
    tick(8);
    chk(powerdown, 1'b0);
    setcfg(`FMB_CFG_RESET);
    burst(3'h2, 1'b0, FMB_LEN_4, 21'h000101, 1'b0, 1'b0);
    burst(3'h6, 1'b1, FMB_LEN_4, 21'h000101, 1'b1, 1'b0);
    burst(3'h3, 1'b1, FMB_LEN_8, 21'h000105, 1'b0, 1'b0);
    burst(3'h4, 1'b0, FMB_LEN_8, 21'h000106, 1'b1, 1'b0);
    burst(3'h2, 1'b0, FMB_LEN_CONT, 21'h00011e, 1'b0, 1'b1);
    burst(3'h3, 1'b0, FMB_LEN_CONT, 21'h00013f, 1'b1, 1'b0);
    test_done;
  end
endmodule : fmb_bus_ctrl_bench
